/* File: core/identify_capability_words.sv */
/*
 * Read-only identify words 65-91 with the live enabled-features word 85,
 * its byte-sum share for the integrity word, and the DMA throttle hint.
 * Assumes a register port master that keeps strobes one cycle long and
 * a command engine that pulses the security password inputs.
 */
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "identify_capability_defs.svh"

// Contract
// - Word 65 reads 120 ns minimum DMA
// - Word 66 reads 120 ns recommended DMA
// - Throttle DMA request when host cycles faster
// - Word 67 reads 120, word 53 bit1 set
// - Word 68 reads 120 ns with IORDY
// - Word 80 sets version bits 6:1
// - Word 81 reads constant 0021H
// - Word 82 reports 706BH
// - Word 82 bit15 zero, bit14 one
// - Word 83 bit15 zero, bit14 one
// - Word 83 bits 13, 12, 10 set
// - Word 83 bit3 set, word 91 zero
// - Word 83 remaining feature bits cleared
// - Word 84 reads 4000H
// - Word 85 bits 14-12 show command enables
// - Word 85 bit10 set, listed bits cleared
// - Word 85 bits 6,5 show look-ahead, cache
// - Word 85 bit3 PM, bit1 after password
// - Byte sum share recomputed on changes
module identify_capability_words #(
    parameter logic EN_NOP_RST       = 1'b1,
    parameter logic EN_RDBUF_RST     = 1'b1,
    parameter logic EN_WRBUF_RST     = 1'b1,
    parameter logic EN_LOOKAHEAD_RST = 1'b1,
    parameter logic EN_WCACHE_RST    = 1'b1,
    parameter logic EN_PM_RST        = 1'b1
) (
    input  wire logic                             mclk_in,
    input  wire logic                             sys_rst_in,
    input  wire identify_capability_pkg::id_addr_t reg_addr_in,
    input  wire identify_capability_pkg::id_word_t reg_wdata_in,
    input  wire logic                             reg_wr_in,
    input  wire logic                             reg_rd_in,
    output logic [15:0]                           reg_rdata_out,
    input  wire logic                             sec_pw_set_in,
    input  wire logic                             sec_disable_in,
    input  wire logic [15:0]                      host_dma_cycle_ns_in,
    input  wire logic                             dma_active_in,
    output logic                                  dma_throttle_out,
    output logic                                  pio_timing_valid_out,
    output logic [7:0]                            byte_sum_out
);

    // ------------------------------------------------------------------
    // Dynamic enable state
    // ------------------------------------------------------------------
    logic [15:0] dyn_q;
    logic        sec_q;
    logic [15:0] dyn_rst;

    assign dyn_rst = (16'(EN_NOP_RST) << `EN_NOP_BIT)
                   | (16'(EN_RDBUF_RST) << `EN_RDBUF_BIT)
                   | (16'(EN_WRBUF_RST) << `EN_WRBUF_BIT)
                   | (16'(EN_LOOKAHEAD_RST) << `EN_LOOKAHEAD_BIT)
                   | (16'(EN_WCACHE_RST) << `EN_WCACHE_BIT)
                   | (16'(EN_PM_RST) << `EN_PM_BIT);

    // Set-features completion writes word 85; the new state is visible
    // to the very next read, so no identify ever returns a stale bit.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            dyn_q <= dyn_rst;
        else if (reg_wr_in && reg_addr_in == `IDW_ENABLED_0)
            dyn_q <= reg_wdata_in & `ENABLED_DYN_MASK;
    end

    // Security can only be raised by the password command, never by a
    // plain write; a set arriving with a disable wins.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            sec_q <= 1'b0;
        else if (sec_pw_set_in)
            sec_q <= 1'b1;
        else if (sec_disable_in)
            sec_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Word decode
    // ------------------------------------------------------------------
    function automatic logic [15:0] word_value(
        input logic [`IDW_ADDR_W-1:0] addr,
        input logic [15:0]            dyn,
        input logic                   sec
    );
        logic [15:0] v;
        v = `UNMAPPED_VAL;
        case (addr)
            `IDW_MIN_DMA:    v = `MIN_DMA_NS;
            `IDW_REC_DMA:    v = `REC_DMA_NS;
            `IDW_PIO_NOFLOW: v = `PIO_NOFLOW_NS;
            `IDW_PIO_IORDY:  v = `PIO_IORDY_NS;
            `IDW_MAJOR_VER:  v = `MAJOR_VER_VAL;
            `IDW_MINOR_VER:  v = `MINOR_VER_VAL;
            `IDW_SUPP_0:     v = `SUPP_0_VAL;
            `IDW_SUPP_1:     v = `SUPP_1_VAL;
            `IDW_SUPP_2:     v = `SUPP_2_VAL;
            `IDW_ENABLED_0:  v = `ENABLED_FIXED | dyn | (16'(sec) << `EN_SECURITY_BIT);
            `IDW_APM_LEVEL:  v = `APM_LEVEL_VAL;
            default:         v = `UNMAPPED_VAL;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Register port: data one cycle after the read strobe
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_rd_in)
            reg_rdata_out <= word_value(reg_addr_in, dyn_q, sec_q);
        else
            reg_rdata_out <= 16'h0000;
    end

    // ------------------------------------------------------------------
    // Integrity share: byte sum of every word served here
    // ------------------------------------------------------------------
    logic [7:0] sum_d;

    always_comb
    begin
        logic [15:0] w;
        w = 16'h0000;
        sum_d = 8'h00;
        for (int a = `IDW_MIN_DMA; a <= `IDW_APM_LEVEL; a++)
        begin
            w = word_value(a[`IDW_ADDR_W-1:0], dyn_q, sec_q);
            sum_d = sum_d + w[7:0] + w[15:8];
        end
    end

    // Recomputed every cycle, so any dynamic change reaches the
    // checksum logic one edge later.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            byte_sum_out <= 8'h00;
        else
            byte_sum_out <= sum_d;
    end

    // ------------------------------------------------------------------
    // Flow control hint and word 53 validity
    // ------------------------------------------------------------------
    // The host may cycle faster than recommended; pausing the request is
    // left to the DMA engine, this only says when it should.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            dma_throttle_out <= 1'b0;
        else
            dma_throttle_out <= dma_active_in && (host_dma_cycle_ns_in < `REC_DMA_NS);
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            pio_timing_valid_out <= 1'b0;
        else
            pio_timing_valid_out <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_read(logic [7:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence

    a_min_dma_word: assert property (s_read(`IDW_MIN_DMA) |=> reg_rdata_out == 16'h0078)
        else $error("word 65 not 120");
    a_rec_dma_word: assert property (s_read(`IDW_REC_DMA) |=> reg_rdata_out == 16'h0078)
        else $error("word 66 not 120");
    a_pio_noflow_word: assert property (s_read(`IDW_PIO_NOFLOW) |=> reg_rdata_out == 16'h0078)
        else $error("word 67 not 120");
    a_pio_iordy_word: assert property (s_read(`IDW_PIO_IORDY) |=> reg_rdata_out == 16'h0078)
        else $error("word 68 not 120");
    a_major_ver_bits: assert property (s_read(`IDW_MAJOR_VER) |=> reg_rdata_out[6:1] == 6'h3F)
        else $error("version bits not set");
    a_minor_ver_word: assert property (s_read(`IDW_MINOR_VER) |=> reg_rdata_out == 16'h0021)
        else $error("word 81 wrong");
    a_supp0_word: assert property (s_read(`IDW_SUPP_0) |=> reg_rdata_out == 16'h706B)
        else $error("word 82 wrong");
    a_supp1_word: assert property (s_read(`IDW_SUPP_1) |=> reg_rdata_out == 16'h7408)
        else $error("word 83 wrong");
    a_supp2_word: assert property (s_read(`IDW_SUPP_2) |=> reg_rdata_out == 16'h4000)
        else $error("word 84 wrong");
    a_apm_level_zero: assert property (s_read(`IDW_APM_LEVEL) |=> reg_rdata_out == 16'h0000)
        else $error("word 91 not zero");
    a_enabled_fixed: assert property (s_read(`IDW_ENABLED_0)
        |=> (reg_rdata_out & 16'h8F95) == 16'h0400)
        else $error("word 85 fixed bits wrong");
    a_enable_update: assert property ((reg_wr_in && reg_addr_in == `IDW_ENABLED_0)
        ##1 s_read(`IDW_ENABLED_0)
        |=> (reg_rdata_out & 16'h7068) == ($past(reg_wdata_in, 2) & 16'h7068))
        else $error("word 85 not updated");
    a_security_set: assert property (sec_pw_set_in ##1 s_read(`IDW_ENABLED_0)
        |=> reg_rdata_out[1])
        else $error("security bit not set");
    a_security_idle: assert property (!$past(sec_pw_set_in) && !$past(sec_q) |-> !sec_q)
        else $error("security bit rose without password");
    a_throttle_hint: assert property (dma_active_in && host_dma_cycle_ns_in < 16'h0078
        |=> dma_throttle_out)
        else $error("no throttle on fast host");

    // ------------------------------------------------------------------
    // Checker helpers
    // ------------------------------------------------------------------
    // True for every word this block serves; anything else reads zero.
    function automatic logic word_mapped(
        input logic [`IDW_ADDR_W-1:0] addr
    );
        logic hit;
        hit = 1'b0;
        case (addr)
            `IDW_MIN_DMA,
            `IDW_REC_DMA,
            `IDW_PIO_NOFLOW,
            `IDW_PIO_IORDY,
            `IDW_MAJOR_VER,
            `IDW_MINOR_VER,
            `IDW_SUPP_0,
            `IDW_SUPP_1,
            `IDW_SUPP_2,
            `IDW_ENABLED_0,
            `IDW_APM_LEVEL: hit = 1'b1;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [7:0] byte_pair(input logic [15:0] w);
        return w[7:0] + w[15:8];
    endfunction

    // Byte sum rebuilt from the constants and dyn_q/sec_q, not word_value, so a decode slip in
    // word_value cannot hide inside its own checksum.
    logic [15:0] ref_w85;
    logic [7:0]  ref_sum;

    assign ref_w85 = `ENABLED_FIXED | dyn_q | (16'(sec_q) << `EN_SECURITY_BIT);

    assign ref_sum = byte_pair(`MIN_DMA_NS)
                   + byte_pair(`REC_DMA_NS)
                   + byte_pair(`PIO_NOFLOW_NS)
                   + byte_pair(`PIO_IORDY_NS)
                   + byte_pair(`MAJOR_VER_VAL)
                   + byte_pair(`MINOR_VER_VAL)
                   + byte_pair(`SUPP_0_VAL)
                   + byte_pair(`SUPP_1_VAL)
                   + byte_pair(`SUPP_2_VAL)
                   + byte_pair(ref_w85)
                   + byte_pair(`APM_LEVEL_VAL);

    sequence s_write(logic [7:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence

    sequence s_quiet_security;
        !sec_pw_set_in && !sec_disable_in;
    endsequence

    // ------------------------------------------------------------------
    // Register port and fixed word checks
    // ------------------------------------------------------------------
    a_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data stands past its cycle");

    a_unmapped_zero: assert property (
        reg_rd_in && !word_mapped(reg_addr_in) |=> reg_rdata_out == 16'h0000)
        else $error("unmapped word not zero");

    a_nop_supported: assert property (
        s_read(`IDW_SUPP_0) |=> reg_rdata_out[15:14] == 2'b01)
        else $error("word 82 top bits wrong");

    a_supp_valid_flag: assert property (
        s_read(`IDW_SUPP_1) |=> reg_rdata_out[15:14] == 2'b01)
        else $error("word 83 top bits wrong");

    a_supp1_cleared: assert property (
        s_read(`IDW_SUPP_1) |=> (reg_rdata_out & 16'h0BF7) == 16'h0000)
        else $error("word 83 denied bits set");

    a_apm_supported: assert property (
        s_read(`IDW_SUPP_1) |=> reg_rdata_out[3])
        else $error("word 83 power bit clear");

    a_supp2_reserved: assert property (
        s_read(`IDW_SUPP_2) |=> reg_rdata_out[13:0] == 14'h0000)
        else $error("word 84 reserved bits set");

    a_major_ver_range: assert property (
        s_read(`IDW_MAJOR_VER) |=> reg_rdata_out != 16'h0000 && reg_rdata_out != 16'hFFFF)
        else $error("word 80 claims no version");

    a_hpa_enabled: assert property (
        s_read(`IDW_ENABLED_0) |=> reg_rdata_out[10])
        else $error("word 85 protected area bit clear");

    a_word53_valid: assert property (
        !$past(sys_rst_in) |-> pio_timing_valid_out)
        else $error("word 53 bit 1 not set");

    // ------------------------------------------------------------------
    // Dynamic state checks
    // ------------------------------------------------------------------
    a_dyn_reset: assert property (
        $past(sys_rst_in) |-> dyn_q == dyn_rst)
        else $error("enable bits wrong after reset");

    a_write_lands: assert property (
        s_write(`IDW_ENABLED_0) |=> dyn_q == ($past(reg_wdata_in) & 16'h7068))
        else $error("word 85 write not stored");

    a_write_masked: assert property (
        s_write(`IDW_ENABLED_0) |=> (dyn_q & 16'h8F97) == 16'h0000)
        else $error("word 85 fixed bits stored");

    a_write_other_kept: assert property (
        reg_wr_in && reg_addr_in != `IDW_ENABLED_0 |=> $stable(dyn_q))
        else $error("write elsewhere changed word 85");

    a_sec_set_wins: assert property (
        sec_pw_set_in |=> sec_q)
        else $error("password set not taken");

    a_sec_disable: assert property (
        sec_disable_in && !sec_pw_set_in |=> !sec_q)
        else $error("security not cleared");

    a_sec_write_immune: assert property (
        s_write(`IDW_ENABLED_0) and s_quiet_security |=> $stable(sec_q))
        else $error("bus write moved security bit");

    a_sum_reference: assert property (
        !$past(sys_rst_in) |-> byte_sum_out == $past(ref_sum))
        else $error("byte sum share wrong");

    // ------------------------------------------------------------------
    // Throttle hint checks
    // ------------------------------------------------------------------
    a_throttle_idle: assert property (
        !(dma_active_in && host_dma_cycle_ns_in < 16'h0078) |=> !dma_throttle_out)
        else $error("throttle without fast host");

    a_throttle_reset: assert property (
        $past(sys_rst_in) |-> !dma_throttle_out)
        else $error("throttle high out of reset");

endmodule

`default_nettype wire

/* File: core/identify_capability_defs.svh */
/*
 * Word numbers, field positions, fixed values and timing figures of the
 * identify capability words 65-91.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef IDENTIFY_CAPABILITY_DEFS_SVH
`define IDENTIFY_CAPABILITY_DEFS_SVH

// ----------------------------------------------------------------------
// Word numbers, used directly as register addresses
// ----------------------------------------------------------------------
`define IDW_ADDR_W          8
`define IDW_MIN_DMA         8'h41
`define IDW_REC_DMA         8'h42
`define IDW_PIO_NOFLOW      8'h43
`define IDW_PIO_IORDY       8'h44
`define IDW_MAJOR_VER       8'h50
`define IDW_MINOR_VER       8'h51
`define IDW_SUPP_0          8'h52
`define IDW_SUPP_1          8'h53
`define IDW_SUPP_2          8'h54
`define IDW_ENABLED_0       8'h55
`define IDW_APM_LEVEL       8'h5B

// ----------------------------------------------------------------------
// Timing figures in nanoseconds
// ----------------------------------------------------------------------
`define MIN_DMA_NS          16'h0078
`define REC_DMA_NS          16'h0078
`define PIO_NOFLOW_NS       16'h0078
`define PIO_IORDY_NS        16'h0078

// ----------------------------------------------------------------------
// Fixed word values
// ----------------------------------------------------------------------
`define MAJOR_VER_VAL       16'h007E
`define MINOR_VER_VAL       16'h0021
`define SUPP_0_VAL          16'h706B
`define SUPP_1_VAL          16'h7408
`define SUPP_2_VAL          16'h4000
`define APM_LEVEL_VAL       16'h0000
`define UNMAPPED_VAL        16'h0000

// ----------------------------------------------------------------------
// Enabled-features word: fixed part and dynamic bit positions
// ----------------------------------------------------------------------
`define ENABLED_FIXED       16'h0400
`define EN_NOP_BIT          14
`define EN_RDBUF_BIT        13
`define EN_WRBUF_BIT        12
`define EN_LOOKAHEAD_BIT    6
`define EN_WCACHE_BIT       5
`define EN_PM_BIT           3
`define EN_SECURITY_BIT     1
`define ENABLED_DYN_MASK    16'h7068
`define ENABLED_ALL_DYN     16'h706A

`endif

/* File: core/identify_capability_pkg.sv */
/*
 * Types shared by the identify capability words block.
 * Assumes the constants header sits beside it.
 */
`include "identify_capability_defs.svh"

package identify_capability_pkg;
    typedef logic [15:0]               id_word_t;
    typedef logic [`IDW_ADDR_W-1:0]    id_addr_t;
    typedef logic [7:0]                id_byte_t;
endpackage

/* File: verif/ata_host_model.sv */
/* Host controller model that reads and writes identify words over the register port.
   Assumes one clock and read data valid only in the cycle after the read strobe. */
`timescale 1ns/1ps
`default_nettype none
module ata_host_model (
    input  wire logic        mclk_in,
    output logic [7:0]       addr_out,
    output logic [15:0]      wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    input  wire logic [15:0] rdata_in
);
    initial
    begin
        addr_out  = 8'h00;
        wdata_out = 16'h0000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end
    // Only word 85 is written, with patterns that also set fixed and unlisted bits
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge mclk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask
    // Released lines show the inverse, so a stale value never looks valid
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge mclk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
/* Self-checking bench for the identify capability words.
   Assumes the host model drives the register port and the bench the rest. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk_in;
    logic        sys_rst_in;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        pw_set;
    logic        sec_off;
    logic [15:0] dma_ns;
    logic        dma_act;
    logic        throttle;
    logic        pio_ok;
    logic [7:0]  bsum;
    int          n_errors;
    int          cmp_count;
    int          cyc;
    logic [15:0] v;
    logic [7:0]  wa[12] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h50, 8'h51, 8'h52, 8'h53,
                            8'h54, 8'h5B, 8'h45, 8'h56};
    logic [15:0] wv[12] = '{16'h0078, 16'h0078, 16'h0078, 16'h0078, 16'h007E, 16'h0021,
                            16'h706B, 16'h7408, 16'h4000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] pat[4] = '{16'h0000, 16'h8F97, 16'hFFFF, 16'h4020};

    identify_capability_words dut_u (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .sec_pw_set_in(pw_set), .sec_disable_in(sec_off), .host_dma_cycle_ns_in(dma_ns),
        .dma_active_in(dma_act), .dma_throttle_out(throttle),
        .pio_timing_valid_out(pio_ok), .byte_sum_out(bsum));
    ata_host_model host_u (
        .mclk_in(mclk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .rdata_in(rdata));

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // Sum covers the fixed words plus the live word 85
    function automatic logic [7:0] sum_exp(input logic [15:0] w85);
        logic [7:0] s;
        s = w85[15:8] + w85[7:0];
        foreach (wv[i]) s = s + wv[i][15:8] + wv[i][7:0];
        return s;
    endfunction
    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic t_fixed;
        foreach (wa[i])
        begin
            host_u.rd(wa[i], v);
            chk("fixed word", v, wv[i]);
        end
        chk("pio valid", {15'h0000, pio_ok}, 16'h0001);
    endtask
    task automatic t_enables;
        logic [15:0] e;
        host_u.rd(8'h55, v);
        chk("word85 reset", v, 16'h7468);
        foreach (pat[i])
        begin
            host_u.wr(8'h55, pat[i]);
            host_u.rd(8'h55, v);
            e = 16'h0400 | (pat[i] & 16'h7068);
            chk("word85", v, e);
            chk("byte sum", {8'h00, bsum}, {8'h00, sum_exp(e)});
        end
    endtask
    task automatic t_security;
        @(posedge mclk_in);
        pw_set <= 1'b1;
        @(posedge mclk_in);
        pw_set <= 1'b0;
        host_u.rd(8'h55, v);
        chk("word85 secured", v, 16'h4422);
        chk("byte sum", {8'h00, bsum}, {8'h00, sum_exp(16'h4422)});
        host_u.wr(8'h55, 16'h0000);
        host_u.rd(8'h55, v);
        chk("word85 bus write", v, 16'h0402);
        @(posedge mclk_in);
        sec_off <= 1'b1;
        @(posedge mclk_in);
        sec_off <= 1'b0;
        host_u.rd(8'h55, v);
        chk("word85 unsecured", v, 16'h0400);
    endtask
    task automatic t_throttle;
        logic        ta[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        logic [15:0] tn[4] = '{16'h0064, 16'h0078, 16'h0050, 16'h0077};
        logic        te[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        foreach (ta[i])
        begin
            @(posedge mclk_in);
            dma_act <= ta[i];
            dma_ns  <= tn[i];
            repeat (2) @(posedge mclk_in);
            #1;
            chk("throttle", {15'h0000, throttle}, {15'h0000, te[i]});
        end
    endtask

    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    // A hang is cut off well past the fewer than a hundred cycles the run needs
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        sys_rst_in = 1'b1;
        pw_set     = 1'b0;
        sec_off    = 1'b0;
        dma_ns     = 16'h0078;
        dma_act    = 1'b0;
        n_errors   = 0;
        cmp_count  = 0;
        cyc        = 0;
        repeat (5) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        t_fixed();
        t_enables();
        t_security();
        t_throttle();
        tally_and_finish();
    end
endmodule
`default_nettype wire
